/* rtl/sample_status_flags.sv */
`timescale 1ns/10ps
//
// Contract
// - Mode 00: address 0x00 reads the per-sample status register at 0x06.
// - Mode above 00: address 0x00 reads the queue status register at 0x0D.
// - Reads auto-increment the address so status and data come in one burst.
// - Mode field: 00 queue off, 01 circular, 10 full stop.
// - Queue off: status and output data update on each completed sample.
// - Combined overwrite sets when a new result lands before previous set is read.
// - Mode zero: combined overwrite clears on pressure or temperature high byte read.
// - Mode above zero: all six flags clear on a read of the queue data port.
// - Pressure overwrite sets when new pressure completes before previous was read.
// - Mode zero: pressure overwrite clears on pressure high byte read.
// - Temperature overwrite sets when new temperature completes before previous was read.
// - Mode zero: temperature overwrite clears on temperature high byte read.
// - Combined ready sets on any new result; mode zero clears on either high byte.
// - Pressure ready sets per pressure result; mode zero clears on pressure high byte.
// - Temperature ready sets per temperature result; mode zero clears on temperature high byte.
// - Pressure flags are generated only while the pressure event enable is set.
// - Temperature flags are generated only while the temperature event enable is set.
// - Combined flags are generated only while the ready event mode is enabled.
// - Standby to active clears status and data output registers to 0x00.
module sample_status_flags (
    input  wire logic                                     clk,
    input  wire logic                                     sys_rst,
    input  wire logic                                     ce,
    input  wire logic                                     addr_load,
    input  wire logic [7:0]                               addr_in,
    input  wire logic                                     rd_req,
    input  wire logic                                     wr_req,
    input  wire logic [7:0]                               wr_data,
    output logic [7:0]                                    rd_data,
    output logic                                          rd_valid,
    input  wire logic [1:0]                               fifo_mode,
    input  wire logic                                     press_event_gen_enable,
    input  wire logic                                     temp_event_gen_enable,
    input  wire logic                                     ready_event_mode,
    input  wire logic                                     standby_to_active,
    input  wire logic                                     press_done,
    input  wire logic [sample_status_pkg::PRESS_WIDTH-1:0] press_data,
    input  wire logic                                     temp_done,
    input  wire logic [sample_status_pkg::TEMP_WIDTH-1:0] temp_data,
    input  wire logic [7:0]                               fifo_data,
    input  wire logic [7:0]                               fifo_status,
    output logic                                          fifo_pop,
    output logic [7:0]                                    sample_ready_status
);

    // ------------------------------------------------------------
    // Address pointer and read decode
    // ------------------------------------------------------------
    logic [7:0]                                     ptr_reg;
    logic [7:0]                                     ptr_next;
    logic [7:0]                                     rd_data_reg;
    logic                                           rd_valid_reg;
    logic [sample_status_pkg::PRESS_WIDTH-1:0]      press_data_reg;
    logic [sample_status_pkg::TEMP_WIDTH-1:0]       temp_data_reg;
    logic [7:0]                                     status_byte;
    logic [7:0]                                     read_mux;
    logic                                           queue_on;
    logic                                           rd_fire;
    logic                                           wr_fire;
    logic                                           press_clear;
    logic                                           temp_clear;
    logic [sample_status_pkg::NUM_CH-1:0]           ch_enable;
    logic [sample_status_pkg::NUM_CH-1:0]           ch_done;
    logic [sample_status_pkg::NUM_CH-1:0]           ch_clear;
    logic [sample_status_pkg::NUM_CH-1:0]           ch_ready;
    logic [sample_status_pkg::NUM_CH-1:0]           ch_overwrite;

    // Auto-increment wraps from the last data byte back to the alias
    function automatic logic [7:0] next_addr(input logic [7:0] a);
        if (a == sample_status_pkg::ADDR_WRAP_LAST) begin
            next_addr = sample_status_pkg::ADDR_ALIAS;
        end else begin
            next_addr = a + sample_status_pkg::ADDR_STEP;
        end
    endfunction

    // Codes 01 and 10 (and the unused 11) all route the queue view
    assign queue_on = (fifo_mode != sample_status_pkg::MODE_OFF);
    assign rd_fire  = ce & rd_req & ~addr_load;
    // Writes only advance the pointer; status stays read-only
    assign wr_fire  = ce & wr_req & ~addr_load;
    assign fifo_pop = rd_fire & queue_on & (ptr_reg == sample_status_pkg::ADDR_PRESS_MSB);

    assign ptr_next = addr_load ? addr_in :
                      ((rd_fire | wr_fire) ? next_addr(ptr_reg) : ptr_reg);

    always_comb begin
        if (ptr_reg == sample_status_pkg::ADDR_ALIAS) begin
            read_mux = queue_on ? fifo_status : status_byte;
        end else if (ptr_reg == sample_status_pkg::ADDR_PRESS_MSB) begin
            read_mux = queue_on ? fifo_data : press_data_reg[19:12];
        end else if (ptr_reg == sample_status_pkg::ADDR_PRESS_CSB) begin
            read_mux = queue_on ? sample_status_pkg::ZERO_BYTE : press_data_reg[11:4];
        end else if (ptr_reg == sample_status_pkg::ADDR_PRESS_LSB) begin
            read_mux = queue_on ? sample_status_pkg::ZERO_BYTE
                                : {press_data_reg[3:0], sample_status_pkg::ZERO_NIBBLE};
        end else if (ptr_reg == sample_status_pkg::ADDR_TEMP_MSB) begin
            read_mux = queue_on ? sample_status_pkg::ZERO_BYTE : temp_data_reg[11:4];
        end else if (ptr_reg == sample_status_pkg::ADDR_TEMP_LSB) begin
            read_mux = queue_on ? sample_status_pkg::ZERO_BYTE
                                : {temp_data_reg[3:0], sample_status_pkg::ZERO_NIBBLE};
        end else if (ptr_reg == sample_status_pkg::ADDR_READY_STATUS) begin
            read_mux = status_byte;
        end else if (ptr_reg == sample_status_pkg::ADDR_QUEUE_STATUS) begin
            read_mux = fifo_status;
        end else begin
            read_mux = sample_status_pkg::ZERO_BYTE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_reg      <= sample_status_pkg::ADDR_ALIAS;
            rd_data_reg  <= sample_status_pkg::ZERO_BYTE;
            rd_valid_reg <= 1'b0;
        end else if (ce) begin
            ptr_reg      <= ptr_next;
            rd_valid_reg <= rd_fire;
            if (rd_fire) begin
                rd_data_reg <= read_mux;
            end
        end
    end

    assign rd_data  = rd_data_reg;
    assign rd_valid = rd_valid_reg & ce;

    // ------------------------------------------------------------
    // Output data registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || (ce && standby_to_active)) begin
            press_data_reg <= '0;
            temp_data_reg  <= '0;
        end else if (ce) begin
            if (press_done) begin
                press_data_reg <= press_data;
            end
            if (temp_done) begin
                temp_data_reg <= temp_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Flag channels
    // ------------------------------------------------------------
    // Mode zero clears per high byte; queue mode clears all on data port read
    assign press_clear = rd_fire & (queue_on ? fifo_pop
                         : (ptr_reg == sample_status_pkg::ADDR_PRESS_MSB));
    assign temp_clear  = rd_fire & (queue_on ? fifo_pop
                         : (ptr_reg == sample_status_pkg::ADDR_TEMP_MSB));

    assign ch_enable[sample_status_pkg::CH_PRESS] = press_event_gen_enable;
    assign ch_enable[sample_status_pkg::CH_TEMP]  = temp_event_gen_enable;
    assign ch_enable[sample_status_pkg::CH_ANY]   = ready_event_mode;
    assign ch_done[sample_status_pkg::CH_PRESS]   = press_done;
    assign ch_done[sample_status_pkg::CH_TEMP]    = temp_done;
    assign ch_done[sample_status_pkg::CH_ANY]     = press_done | temp_done;
    assign ch_clear[sample_status_pkg::CH_PRESS]  = press_clear;
    assign ch_clear[sample_status_pkg::CH_TEMP]   = temp_clear;
    assign ch_clear[sample_status_pkg::CH_ANY]    = press_clear | temp_clear;

    genvar g;
    generate
        for (g = 0; g < sample_status_pkg::NUM_CH; g = g + 1) begin : g_ch
            status_flag_pair u_flags (
                .clk            (clk),
                .sys_rst        (sys_rst),
                .ce             (ce),
                .clear_all      (standby_to_active),
                .gen_enable     (ch_enable[g]),
                .done           (ch_done[g]),
                .rd_clear       (ch_clear[g]),
                .ready_flag     (ch_ready[g]),
                .overwrite_flag (ch_overwrite[g])
            );
        end
    endgenerate

    always_comb begin
        status_byte = sample_status_pkg::ZERO_BYTE;
        status_byte[sample_status_pkg::BIT_ANY_OW]    = ch_overwrite[sample_status_pkg::CH_ANY];
        status_byte[sample_status_pkg::BIT_PRESS_OW]  = ch_overwrite[sample_status_pkg::CH_PRESS];
        status_byte[sample_status_pkg::BIT_TEMP_OW]   = ch_overwrite[sample_status_pkg::CH_TEMP];
        status_byte[sample_status_pkg::BIT_ANY_READY] = ch_ready[sample_status_pkg::CH_ANY];
        status_byte[sample_status_pkg::BIT_PRESS_RDY] = ch_ready[sample_status_pkg::CH_PRESS];
        status_byte[sample_status_pkg::BIT_TEMP_RDY]  = ch_ready[sample_status_pkg::CH_TEMP];
    end

    assign sample_ready_status = status_byte;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_alias_ready_view: assert property (
        rd_fire && ptr_reg == sample_status_pkg::ADDR_ALIAS && !queue_on
        |=> rd_data_reg == $past(status_byte))
        else $error("alias did not show sample status");

    a_alias_queue_view: assert property (
        rd_fire && ptr_reg == sample_status_pkg::ADDR_ALIAS && queue_on
        |=> rd_data_reg == $past(fifo_status))
        else $error("alias did not show queue status");

    a_burst_increment: assert property (
        rd_fire && ptr_reg < sample_status_pkg::ADDR_WRAP_LAST
        |=> ptr_reg == $past(ptr_reg) + sample_status_pkg::ADDR_STEP)
        else $error("address did not auto-increment");

    a_press_data_live: assert property (
        ce && press_done && !standby_to_active |=> press_data_reg == $past(press_data))
        else $error("pressure output not updated");

    a_press_ow_set: assert property (
        ce && press_done && press_event_gen_enable && !standby_to_active && ch_ready[0]
        |=> ch_overwrite[0])
        else $error("pressure overwrite not set");

    a_press_gen_gate: assert property (
        ce && !press_event_gen_enable && !standby_to_active && !ch_ready[0] |=> !ch_ready[0])
        else $error("pressure ready set while disabled");

    a_temp_mode0_clear: assert property (
        rd_fire && !queue_on && ptr_reg == sample_status_pkg::ADDR_TEMP_MSB && !temp_done
        |=> !ch_ready[1] && !ch_overwrite[1])
        else $error("temperature flags not cleared by high byte");

    a_any_mode0_clear: assert property (
        rd_fire && !queue_on && ptr_reg == sample_status_pkg::ADDR_PRESS_MSB
        && !press_done && !temp_done |=> !ch_overwrite[2] && !ch_ready[2])
        else $error("combined flags not cleared");

    a_queue_clear_all: assert property (
        fifo_pop && !press_done && !temp_done |=> status_byte == sample_status_pkg::ZERO_BYTE)
        else $error("queue data read did not clear flags");

    a_status_read_keep: assert property (
        rd_fire && ptr_reg == sample_status_pkg::ADDR_READY_STATUS && !press_done
        && !temp_done && !standby_to_active |=> $stable(status_byte))
        else $error("status read changed flags");

    a_activate_zero: assert property (
        ce && standby_to_active |=> status_byte == sample_status_pkg::ZERO_BYTE
        && press_data_reg == '0 && temp_data_reg == '0)
        else $error("activation did not clear registers");

    c_burst_read: cover property (rd_fire ##1 rd_fire ##1 rd_fire);
    c_press_overwrite: cover property (ch_overwrite[0]);
    c_queue_pop: cover property (fifo_pop);
    c_set_and_clear: cover property (press_clear && press_done && press_event_gen_enable);

endmodule // sample_status_flags

/* rtl/sample_status_pkg.sv */
package sample_status_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ALIAS        = 8'h00;
    localparam logic [7:0] ADDR_PRESS_MSB    = 8'h01;
    localparam logic [7:0] ADDR_PRESS_CSB    = 8'h02;
    localparam logic [7:0] ADDR_PRESS_LSB    = 8'h03;
    localparam logic [7:0] ADDR_TEMP_MSB     = 8'h04;
    localparam logic [7:0] ADDR_TEMP_LSB     = 8'h05;
    localparam logic [7:0] ADDR_READY_STATUS = 8'h06;
    localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h0d;
    localparam logic [7:0] ADDR_WRAP_LAST    = 8'h05;
    localparam logic [7:0] ADDR_STEP         = 8'h01;

    // ------------------------------------------------------------
    // Queue output mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_CIRCULAR = 2'h1;
    localparam logic [1:0] MODE_FULLSTOP = 2'h2;

    // ------------------------------------------------------------
    // Status byte layout and flag channels
    // ------------------------------------------------------------
    localparam int BIT_ANY_OW     = 7;
    localparam int BIT_PRESS_OW   = 6;
    localparam int BIT_TEMP_OW    = 5;
    localparam int BIT_ANY_READY  = 3;
    localparam int BIT_PRESS_RDY  = 2;
    localparam int BIT_TEMP_RDY   = 1;
    localparam int CH_PRESS       = 0;
    localparam int CH_TEMP        = 1;
    localparam int CH_ANY         = 2;
    localparam int NUM_CH         = 3;

    localparam int PRESS_WIDTH    = 20;
    localparam int TEMP_WIDTH     = 12;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [3:0] ZERO_NIBBLE = 4'h0;

endpackage

/* rtl/status_flag_pair.sv */
`timescale 1ns/10ps
// Ready flag plus overwrite flag for one result channel
module status_flag_pair (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic clear_all,
    input  wire logic gen_enable,
    input  wire logic done,
    input  wire logic rd_clear,
    output logic      ready_flag,
    output logic      overwrite_flag
);

    logic ready_next;
    logic overwrite_next;
    logic set_ev;

    // Set beats a read clear in the same cycle
    assign set_ev         = done & gen_enable;
    assign ready_next     = clear_all ? 1'b0 : (set_ev ? 1'b1 : (rd_clear ? 1'b0 : ready_flag));
    assign overwrite_next = clear_all ? 1'b0 :
                            ((set_ev & ready_flag) ? 1'b1 : (rd_clear ? 1'b0 : overwrite_flag));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_flag     <= 1'b0;
            overwrite_flag <= 1'b0;
        end else if (ce) begin
            ready_flag     <= ready_next;
            overwrite_flag <= overwrite_next;
        end
    end

endmodule // status_flag_pair

/* sim/host_reader.sv */
`timescale 1ns/10ps
// Host side of the register bus: loads the pointer, then reads or writes one byte per request
module host_reader (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            addr_load,
    output logic [7:0]      addr_in,
    output logic            rd_req,
    output logic            wr_req,
    output logic [7:0]      wr_data
);
    initial begin
        addr_load = 1'b0;
        addr_in   = 8'h00;
        rd_req    = 1'b0;
        wr_req    = 1'b0;
        wr_data   = 8'h00;
    end

    task automatic point(input logic [7:0] a);
        @(posedge clk);
        addr_load <= 1'b1;
        addr_in   <= a;
        @(posedge clk);
        addr_load <= 1'b0;
        addr_in   <= ~a;
    endtask

    // Answer comes the cycle after the taking edge; bounded wait
    task automatic rd(output logic [7:0] d, output logic ok);
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        ok = 1'b0;
        d  = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d  = rd_data;
            end else begin
                @(posedge clk);
            end
        end
    endtask

    task automatic wr(input logic [7:0] v);
        @(posedge clk);
        wr_req  <= 1'b1;
        wr_data <= v;
        @(posedge clk);
        wr_req  <= 1'b0;
        wr_data <= ~v;
    endtask
endmodule // host_reader

/* sim/sample_status_flags_tb_top.sv */
`timescale 1ns/10ps
module sample_status_flags_tb_top;
    logic clk, sys_rst, ce, addr_load, rd_req, wr_req, rd_valid, fifo_pop, standby_to_active;
    logic press_done, temp_done, pen, ten, rem;
    logic [7:0]  addr_in, wr_data, rd_data, fifo_data, fifo_status, sample_ready_status, st, ptr;
    logic [1:0]  mode;
    logic [19:0] press_data, pd;
    logic [11:0] temp_data, td;
    int n_fail, comparisons, cyc, pops, exp_pops;
    logic [7:0] addrs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0d, 8'h07, 8'h20};

    sample_status_flags dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .addr_load(addr_load), .addr_in(addr_in),
        .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .fifo_mode(mode), .press_event_gen_enable(pen), .temp_event_gen_enable(ten), .ready_event_mode(rem),
        .standby_to_active(standby_to_active), .press_done(press_done), .press_data(press_data),
        .temp_done(temp_done), .temp_data(temp_data), .fifo_data(fifo_data), .fifo_status(fifo_status),
        .fifo_pop(fifo_pop), .sample_ready_status(sample_ready_status));
    host_reader host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .addr_load(addr_load),
        .addr_in(addr_in), .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fifo_pop === 1'b1) pops <= pops + 1;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Expected register view
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        logic on;
        on = (mode != sample_status_pkg::MODE_OFF);
        case (a)
            8'h00: return on ? fifo_status : st;
            8'h01: return on ? fifo_data : pd[19:12];
            8'h02: return on ? 8'h00 : pd[11:4];
            8'h03: return on ? 8'h00 : {pd[3:0], 4'h0};
            8'h04: return on ? 8'h00 : td[11:4];
            8'h05: return on ? 8'h00 : {td[3:0], 4'h0};
            8'h06: return st;
            8'h0d: return fifo_status;
            default: return 8'h00;
        endcase
    endfunction

    task automatic read_next();
        logic [7:0] d, e;
        logic ok;
        e = exp_rd(ptr);
        host.rd(d, ok);
        if (!ok) check(~e, e);
        else check(d, e);
        if (mode != sample_status_pkg::MODE_OFF && ptr == 8'h01) begin
            st = 8'h00;
            exp_pops++;
        end else if (mode == sample_status_pkg::MODE_OFF && (ptr == 8'h01 || ptr == 8'h04)) begin
            st[sample_status_pkg::BIT_ANY_OW] = 1'b0;
            st[sample_status_pkg::BIT_ANY_READY] = 1'b0;
            if (ptr == 8'h01) st[sample_status_pkg::BIT_PRESS_OW] = 1'b0;
            if (ptr == 8'h01) st[sample_status_pkg::BIT_PRESS_RDY] = 1'b0;
            if (ptr == 8'h04) st[sample_status_pkg::BIT_TEMP_OW] = 1'b0;
            if (ptr == 8'h04) st[sample_status_pkg::BIT_TEMP_RDY] = 1'b0;
        end
        ptr = (ptr == 8'h05) ? 8'h00 : ptr + 8'h01;
        #1 check(sample_ready_status, st);
    endtask

    task automatic done_ev(input logic p, input logic t);
        logic [19:0] pv;
        logic [11:0] tv;
        pv = 20'($urandom);
        tv = 12'($urandom);
        @(posedge clk);
        press_done <= p;
        temp_done  <= t;
        press_data <= pv;
        temp_data  <= tv;
        @(posedge clk);
        press_done <= 1'b0;
        temp_done  <= 1'b0;
        if (p) pd = pv;
        if (t) td = tv;
        if (p && pen) st[sample_status_pkg::BIT_PRESS_OW] |= st[sample_status_pkg::BIT_PRESS_RDY];
        if (p && pen) st[sample_status_pkg::BIT_PRESS_RDY] = 1'b1;
        if (t && ten) st[sample_status_pkg::BIT_TEMP_OW] |= st[sample_status_pkg::BIT_TEMP_RDY];
        if (t && ten) st[sample_status_pkg::BIT_TEMP_RDY] = 1'b1;
        if ((p || t) && rem) st[sample_status_pkg::BIT_ANY_OW] |= st[sample_status_pkg::BIT_ANY_READY];
        if ((p || t) && rem) st[sample_status_pkg::BIT_ANY_READY] = 1'b1;
        #1 check(sample_ready_status, st);
    endtask

    initial begin
        {sys_rst, standby_to_active, press_done, temp_done} = 4'hf;
        {press_done, temp_done, standby_to_active} = 3'h0;
        ce = 1'b1;
        {pen, ten, rem, mode, cyc, pops, exp_pops, n_fail, comparisons} = '0;
        {press_data, temp_data, pd, td, st, ptr, fifo_data, fifo_status} = '0;
        void'($urandom(32'hcd3cc282));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        {pen, ten, rem} <= 3'h7;
        done_ev(1'b1, 1'b1);
        done_ev(1'b1, 1'b1);
        host.point(8'h00);
        repeat (7) read_next();
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            mode <= 2'($urandom_range(0, 3));
            {pen, ten, rem} <= 3'($urandom);
            fifo_data <= 8'($urandom);
            fifo_status <= 8'($urandom);
            @(posedge clk);
            repeat ($urandom_range(0, 3)) done_ev(1'($urandom), 1'($urandom));
            if (i % 10 == 9) begin
                @(posedge clk);
                standby_to_active <= 1'b1;
                @(posedge clk);
                standby_to_active <= 1'b0;
                {st, pd, td} = '0;
                #1 check(sample_ready_status, st);
            end
            // Clock enable low: a completed sample must leave flags and data untouched
            if (i % 10 == 4) begin
                @(posedge clk);
                ce         <= 1'b0;
                press_done <= 1'b1;
                temp_done  <= 1'b1;
                press_data <= 20'($urandom);
                temp_data  <= 12'($urandom);
                @(posedge clk);
                {press_done, temp_done, ce} <= 3'h1;
                #1 check(sample_ready_status, st);
            end
            ptr = (i % 3 == 0) ? 8'h00 : addrs[$urandom_range(0, 9)];
            host.point(ptr);
            if (i % 4 == 1) begin
                host.wr(8'hff);
                ptr = (ptr == 8'h05) ? 8'h00 : ptr + 8'h01;
            end
            repeat ((i % 3 == 0) ? 7 : $urandom_range(1, 3)) read_next();
        end
        repeat (2) @(posedge clk);
        check(8'(pops), 8'(exp_pops));
        conclude();
    end
endmodule // sample_status_flags_tb_top
